// file: design/dmba_arbiter.sv
// Purpose: fixed-priority arbiter for cpu, dma and debug access to data memory
// Assumes: requests synchronous to clk; a master holds its request for its whole access
// Notes: grant follows one cycle after a request; handover to a waiter is back to back
// Notes: fixed priority only, so a master that never lets go of req keeps the bus for good
// Notes: reserved control values fall back to the default order rather than a guessed one
// Notes: the enable freezes grant, state and setting together so they never drift apart

`timescale 1ns/1ps
`default_nettype none

module dmba_arbiter
  import dmba_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire dmba_pkg::dmba_masters_t req,
  input  wire logic [15:0]             master_priority_control,
  output var  dmba_pkg::dmba_masters_t grant_q,
  output var  logic                    busy_q,
  output var  logic                    dma_raised_q
);
  import dmba_pkg::*;

  dmba_state_t   state_q;
  dmba_state_t   state_d;
  dmba_masters_t grant_d;
  logic [2:0]    level    [DMBA_NUM_MASTERS];
  wire  logic [2:0] req_v;
  wire  logic [2:0] grant_v;
  wire  logic [2:0] win_v;
  wire  logic       hold;
  wire  logic       raised_d;

  assign req_v   = req;
  assign grant_v = grant_q;

  // reserved control values fall back to the default order
  assign raised_d = (master_priority_control == DMBA_PRIO_DMA_RAISED); // RULE5 RULE9

  // level map: raising dma pushes the cpu to level one, debug never moves
  // levels run from top (0) to bottom (4); only 0, 1, 3 and 4 are ever handed out
  // the map reads the registered setting, so a change on the input steers the
  // decision one edge later and never the one already in flight
  // trade-off: one cycle of latency on a setting change buys a clean boundary
  always_comb begin
    level[DMBA_IDX_CPU] = dma_raised_q ? DMBA_LEVEL_ONE : DMBA_LEVEL_TOP; // RULE3 RULE5
    level[DMBA_IDX_DMA] = dma_raised_q ? DMBA_LEVEL_TOP : DMBA_LEVEL_THREE; // RULE4 RULE7
    level[DMBA_IDX_DBG] = DMBA_LEVEL_BOTTOM; // RULE3 RULE8
  end

  // a requester wins when no other requester holds a lower level number
  // levels are distinct per setting, so at most one requester can win
  // one comparator per pair keeps the decode flat and shallow
  genvar gi;
  genvar gj;
  generate
    for (gi = 0; gi < DMBA_NUM_MASTERS; gi++) begin : g_win
      wire logic [2:0] beaten;
      for (gj = 0; gj < DMBA_NUM_MASTERS; gj++) begin : g_cmp
        assign beaten[gj] = (gi != gj) && req_v[gj] && (level[gj] < level[gi]); // RULE2
      end
      assign win_v[gi] = req_v[gi] && !(|beaten); // RULE1 RULE2
    end
  endgenerate

  // owner keeps the bus while it still requests; new choice only at the boundary
  // the boundary is the edge where the owner's req is seen low: the winner among
  // the waiters is granted at that same edge, so the bus never idles in between
  // waiters are never told they stall; they simply keep req high
  assign hold    = |(grant_v & req_v); // RULE10
  assign grant_d = hold ? grant_q : dmba_masters_t'(win_v); // RULE2 RULE10
  assign state_d = (|grant_d) ? ARB_OWNED : ARB_IDLE;

  // setting is re-sampled every enabled cycle so a running change steers the next decision
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_raised_q <= DMBA_RAISED_RESET; // RULE10
    end else if (ce) begin
      dma_raised_q <= raised_d; // RULE9
    end
  end

  // grant and ownership state
  always_ff @(posedge clk) begin
    if (rst) begin
      grant_q <= DMBA_GRANT_RESET;
      state_q <= ARB_IDLE;
      busy_q  <= 1'b0;
    end else if (ce) begin
      grant_q <= grant_d;
      state_q <= state_d;
      busy_q  <= (state_d == ARB_OWNED);
    end
  end

  // checks; all sample on the rising edge and all but the reset check sleep through reset
  // a grant stands for the whole access, so most checks look one edge ahead

  // at most one owner at any time
  grant_onehot_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    $onehot0(grant_v)) else $error("more than one master granted");

  // a free bus with any request must not stay idle
  free_bus_grants_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    ce && !hold && (|req_v) |=> (|grant_v)) else $error("request on free bus not granted");

  // the owner keeps the bus for as long as it asks
  access_kept_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    ce && hold |=> grant_v == $past(grant_v)) else $error("granted access interrupted");

  // default order puts the cpu on top
  cpu_top_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    ce && !dma_raised_q && !hold && req_v[DMBA_IDX_CPU] |=> grant_v[DMBA_IDX_CPU])
    else $error("cpu not granted first by default");

  // debug only gets the bus when nobody else asks
  dbg_last_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    ce && !hold && req_v[DMBA_IDX_DBG] && (req_v[DMBA_IDX_CPU] || req_v[DMBA_IDX_DMA])
    |=> !grant_v[DMBA_IDX_DBG]) else $error("debug master won over a higher master");

  // dma at level three still sits above debug
  dma_over_dbg_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && !hold && req_v[DMBA_IDX_DMA] && !req_v[DMBA_IDX_CPU] |=> grant_v[DMBA_IDX_DMA])
    else $error("dma lost to debug master");

  // raised setting puts dma on top
  raised_dma_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    ce && dma_raised_q && !hold && req_v[DMBA_IDX_DMA] |=> grant_v[DMBA_IDX_DMA])
    else $error("raised dma not granted first");

  // raised setting leaves the cpu second
  raised_cpu_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    ce && dma_raised_q && !hold && req_v[DMBA_IDX_CPU] && !req_v[DMBA_IDX_DMA]
    |=> grant_v[DMBA_IDX_CPU]) else $error("cpu not second under raised setting");

  // masters below the cpu keep their order
  lower_order_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    ce && dma_raised_q && !hold && req_v[DMBA_IDX_DBG] && req_v[DMBA_IDX_CPU] && !req_v[DMBA_IDX_DMA]
    |=> grant_v[DMBA_IDX_CPU] && !grant_v[DMBA_IDX_DBG]) else $error("order below cpu changed");

  // the setting register follows its input one edge later
  setting_taken_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    ce |=> dma_raised_q == ($past(master_priority_control) == DMBA_PRIO_DMA_RAISED))
    else $error("priority setting not applied");

  // reset wins over enable and setting alike
  reset_default_a: assert property (@(posedge clk) // RULE10
    rst |=> !dma_raised_q && !(|grant_v) && !busy_q) else $error("reset did not restore default");

  // busy flag and ownership state move together
  busy_state_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    busy_q == (state_q == ARB_OWNED)) else $error("busy flag and state disagree");

  // busy means some master owns the bus
  busy_grant_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    busy_q == (|grant_v)) else $error("busy flag and grant disagree");

  // a low enable freezes every register
  ce_freeze_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    !ce |=> $stable(grant_v) && $stable(busy_q) && $stable(dma_raised_q))
    else $error("state moved while enable low");

  // level one stays out of reach of dma, and debug stays at the bottom level
  reserved_level_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    (level[DMBA_IDX_DMA] != DMBA_LEVEL_ONE) && (level[DMBA_IDX_DBG] == DMBA_LEVEL_BOTTOM)
    && (level[DMBA_IDX_CPU] <= DMBA_LEVEL_ONE)) else $error("reserved level handed out");

  // all three masters collide on a free bus
  all_collide_c: cover property (@(posedge clk) disable iff (rst)
    ce && !hold && (&req_v));

  // back to back handover to a waiter
  handover_c: cover property (@(posedge clk) disable iff (rst)
    ce && (|grant_v) && !hold && (|req_v) ##1 (|grant_v));

  // raised dma beats a waiting cpu
  raised_win_c: cover property (@(posedge clk) disable iff (rst)
    ce && dma_raised_q && !hold && req_v[DMBA_IDX_CPU] && req_v[DMBA_IDX_DMA] ##1 grant_v[DMBA_IDX_DMA]);

  // default order: cpu beats a waiting dma
  default_win_c: cover property (@(posedge clk) disable iff (rst)
    ce && !dma_raised_q && !hold && req_v[DMBA_IDX_CPU] && req_v[DMBA_IDX_DMA] ##1 grant_v[DMBA_IDX_CPU]);

  // setting changes while an access runs
  setting_flip_c: cover property (@(posedge clk) disable iff (rst)
    ce && hold && !dma_raised_q && (master_priority_control == DMBA_PRIO_DMA_RAISED));

endmodule

`default_nettype wire

// file: design/dmba_pkg.sv
// Purpose: shared constants and types for the data memory bus arbiter
// Assumes: one system clock, synchronous active-high reset
// Notes: priority levels follow a five-level scale, lower number wins
//
// Overview of operation
// RULE1 - The arbiter decides who owns the data memory bus, extended data space included, among cpu, dma and debug.
// RULE2 - On colliding requests the highest-priority master is granted and the rest wait until its access ends.
// RULE3 - By default the cpu sits at the top level and the debug master at the bottom level.
// RULE4 - By default the dma sits at level three, and levels one and two are never given to any master; the code gives the cpu level one under 0x0020.
// RULE5 - A control value of zero orders cpu, dma, debug; the value 0x0020 orders dma, cpu (level one), debug.
// RULE6 - Software writes only those two control values; every other value is reserved.
// RULE7 - Masters raised above the cpu keep their relative order among themselves.
// RULE8 - Masters below the cpu keep their relative order whatever setting is in force.
// RULE9 - A new setting is taken at any time, at start-up or while running, and steers later decisions.
// RULE10 - Reset restores the default setting; requests are weighed at each access boundary; a granted access runs on.

package dmba_pkg;

  // one bit per bus master, cpu in bit 0
  typedef struct packed {
    logic dbg;
    logic dma;
    logic cpu;
  } dmba_masters_t;

  typedef enum logic [0:0] {
    ARB_IDLE,
    ARB_OWNED
  } dmba_state_t;

  localparam int unsigned DMBA_NUM_MASTERS = 3;
  localparam int unsigned DMBA_IDX_CPU     = 0;
  localparam int unsigned DMBA_IDX_DMA     = 1;
  localparam int unsigned DMBA_IDX_DBG     = 2;

  // master priority control encodings
  localparam logic [15:0] DMBA_PRIO_DEFAULT    = 16'h0000;
  localparam logic [15:0] DMBA_PRIO_DMA_RAISED = 16'h0020;

  // priority levels, 0 highest; 1 only ever held by the cpu under the raised setting, 2 never held
  localparam logic [2:0] DMBA_LEVEL_TOP    = 3'h0;
  localparam logic [2:0] DMBA_LEVEL_ONE    = 3'h1;
  localparam logic [2:0] DMBA_LEVEL_THREE  = 3'h3;
  localparam logic [2:0] DMBA_LEVEL_BOTTOM = 3'h4;

  // reset values
  localparam logic          DMBA_RAISED_RESET = 1'b0;
  localparam dmba_masters_t DMBA_GRANT_RESET  = '0;

endpackage

// file: tb/dmba_masters_model.sv
// Purpose: cpu, dma and debug masters facing the arbiter
// Assumes: kick is a one-cycle pulse
// Notes: a granted master keeps req for len+1 cycles
`timescale 1ns/1ps
`default_nettype none
module dmba_masters_model
  import dmba_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire dmba_pkg::dmba_masters_t kick,
  input  wire dmba_pkg::dmba_masters_t grant,
  input  wire logic [1:0]              len,
  output var  dmba_pkg::dmba_masters_t req
);
  logic [1:0] cnt [3];
  // a waiting master just keeps req high, it never gives up
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        req[i] <= 1'b0;
        cnt[i] <= 2'h0;
      end else if (kick[i]) begin
        req[i] <= 1'b1;
      end else if (req[i] && grant[i]) begin
        cnt[i] <= (cnt[i] == len) ? 2'h0 : cnt[i] + 2'h1;
        if (cnt[i] == len) req[i] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the data memory bus arbiter
// Assumes: outputs change only on rising clk
// Notes: each new owner is matched against a queue
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dmba_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce  = 1'b1;
  logic [15:0]   pc  = 16'h0000;
  logic [15:0]   rsv;
  logic [1:0]    len = 2'h2;
  dmba_masters_t kick = '0;
  dmba_masters_t req, grant_q;
  dmba_masters_t prev_q = '0;
  logic          busy_q, dma_raised_q;
  dmba_masters_t exp_q[$];
  int            num_errors = 0;
  int            cmp_count = 0;
  always #20 clk = ~clk;
  dmba_arbiter dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .master_priority_control(pc),
    .grant_q(grant_q), .busy_q(busy_q), .dma_raised_q(dma_raised_q));
  dmba_masters_model masters (.clk(clk), .rst(rst), .kick(kick), .grant(grant_q), .len(len), .req(req));
  task automatic cmp_grant(dmba_masters_t e, dmba_masters_t g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t grant %b not %b", $time, g, e);
    end
  endtask
  task automatic cmp_bit(logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t flag %b not %b", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a fresh owner takes the oldest note
  always @(posedge clk) begin
    if (grant_q !== prev_q && grant_q !== '0)
      cmp_grant(exp_q.size() ? exp_q.pop_front() : '0, grant_q);
    prev_q <= grant_q;
  end
  // second kick lands while the first access still runs
  task automatic go(string n, logic [15:0] p1, dmba_masters_t k1, logic [15:0] p2, dmba_masters_t k2,
                    dmba_masters_t e0, dmba_masters_t e1, dmba_masters_t e2);
    exp_q = '{e0, e1, e2};
    pc <= p1;
    repeat (2) @(posedge clk);
    kick <= k1;
    @(posedge clk) kick <= '0;
    @(posedge clk) kick <= k2;
    pc <= p2;
    @(posedge clk) kick <= '0;
    repeat ($urandom_range(2)) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    for (int i = 0; i < 60 && (exp_q.size() || busy_q !== 1'b0 || req !== '0); i++) @(posedge clk);
    cmp_bit(1'b0, busy_q);
    cmp_bit(1'b0, exp_q.size() != 0);
    cmp_bit(pc == 16'h0020, dma_raised_q);
    $display("test %s done", n);
  endtask
  initial begin
    void'($urandom(57));
    repeat (16) @(posedge clk);
    cmp_bit(1'b0, dma_raised_q);
    rst <= 1'b0;
    go("default", 16'h0000, 3'h7, 16'h0000, 3'h0, 3'h1, 3'h2, 3'h4);
    go("raised", 16'h0020, 3'h7, 16'h0020, 3'h0, 3'h2, 3'h1, 3'h4);
    rsv = 16'($urandom);
    if (rsv == 16'h0020) rsv = 16'h0021;
    len <= {1'b1, 1'($urandom)};
    go("reserved", rsv, 3'h7, rsv, 3'h0, 3'h1, 3'h2, 3'h4);
    go("no preempt", 16'h0000, 3'h1, 16'h0020, 3'h6, 3'h1, 3'h2, 3'h4);
    go("low first", 16'h0000, 3'h4, 16'h0000, 3'h3, 3'h4, 3'h1, 3'h2);
    rst <= 1'b1;
    pc <= 16'h0020;
    repeat (2) @(posedge clk);
    cmp_bit(1'b0, dma_raised_q);
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
